// *** rtl/stmh_defines.vh ***
/*
 constants for the target message handler: message codes, identify fields,
 decoded message classes, user operations, byte contexts and handshake timing.
 assumes inclusion by bare name from the design files.
*/
`ifndef STMH_DEFINES_VH
`define STMH_DEFINES_VH

// message codes
`define STMH_MSG_CMD_COMPLETE 8'h00
`define STMH_MSG_SAVE_PTR 8'h02
`define STMH_MSG_RESTORE_PTR 8'h03
`define STMH_MSG_DISCONNECT 8'h04
`define STMH_MSG_INIT_ERR 8'h05
`define STMH_MSG_ABORT 8'h06
`define STMH_MSG_REJECT 8'h07
`define STMH_MSG_NOP 8'h08
`define STMH_MSG_PAR_ERR 8'h09
`define STMH_MSG_BUS_RESET 8'h0c
`define STMH_MSG_IDENTIFY 8'h80

// identify fields
`define STMH_ID_BIT 7
`define STMH_ID_DISC_BIT 6
`define STMH_ID_LUN_MSB 2
`define STMH_LUN_ZERO 3'h0

// decoded incoming message classes
`define STMH_CLS_UNSUP 4'h0
`define STMH_CLS_INIT_ERR 4'h1
`define STMH_CLS_ABORT 4'h2
`define STMH_CLS_REJECT 4'h3
`define STMH_CLS_NOP 4'h4
`define STMH_CLS_PAR_ERR 4'h5
`define STMH_CLS_BUS_RESET 4'h6
`define STMH_CLS_IDENTIFY 4'h7

// user operations
`define STMH_OP_COMPLETE 3'h0
`define STMH_OP_SAVE_PTR 3'h1
`define STMH_OP_RESTORE_PTR 3'h2
`define STMH_OP_DISCONNECT 3'h3
`define STMH_OP_RESELECT 3'h4

// what follows a finished byte
`define STMH_CTX_RX 3'h0
`define STMH_CTX_STATUS 3'h1
`define STMH_CTX_CC 3'h2
`define STMH_CTX_DISC 3'h3
`define STMH_CTX_MSG 3'h4

// handshake timing
`define STMH_SETUP_CYC 4'h2

`endif

// *** rtl/stmh_msg_decode.v ***
/*
 combinational decoder for one incoming message byte: class, identify
 fields and odd bus parity check.
 assumes a byte already captured by the target handshake.
*/
`default_nettype none
`include "stmh_defines.vh"

module stmh_msg_decode (
	input wire [7:0] byte_in,
	input wire par_in,
	input wire check_en,
	output reg [3:0] cls,
	output wire lun_zero,
	output wire disc_perm,
	output wire par_ok
);
	// odd parity over data and parity bit
	assign par_ok = ~check_en | (^{byte_in, par_in});
	assign lun_zero = (byte_in[`STMH_ID_LUN_MSB:0] == `STMH_LUN_ZERO);
	assign disc_perm = byte_in[`STMH_ID_DISC_BIT];

	always @* begin
		cls = `STMH_CLS_UNSUP;
		if (byte_in[`STMH_ID_BIT]) begin
			cls = `STMH_CLS_IDENTIFY;
		end else begin
			// only the accepted incoming set, no extended or linked codes
			case (byte_in)
				`STMH_MSG_INIT_ERR: cls = `STMH_CLS_INIT_ERR;
				`STMH_MSG_ABORT: cls = `STMH_CLS_ABORT;
				`STMH_MSG_REJECT: cls = `STMH_CLS_REJECT;
				`STMH_MSG_NOP: cls = `STMH_CLS_NOP;
				`STMH_MSG_PAR_ERR: cls = `STMH_CLS_PAR_ERR;
				`STMH_MSG_BUS_RESET: cls = `STMH_CLS_BUS_RESET;
				default: cls = `STMH_CLS_UNSUP;
			endcase
		end
	end
endmodule // stmh_msg_decode

`default_nettype wire

// *** rtl/stmh_target.v ***
/*
 target-side message and status engine for a parallel scsi tape target.
 assumes bus inputs already synchronous to clk and active high; command and
 data phases are run by logic outside this block.
*/
// Behaviour
// - only command complete, save pointer, restore pointers, disconnect, reject and identify go out, and only initiator error, abort, reject, nop, message parity error, bus device reset and identify are accepted.
// - extended messages and linked-command messages are neither sent nor honoured.
// - command complete is sent only after the status byte has gone out, on success or failure.
// - after command complete the target releases the bus to bus free.
// - bus parity checking is switched by mode select or by a hardware switch.
// - all transfers use the asynchronous req/ack handshake only.
// - differential drivers are enabled only while diffsens is high.
// - the target works with one or many initiators and ties its command to the one that issued it.
// - after sending disconnect the target releases bsy and must reselect to finish.
// - identify has bit 7 set, bit 6 the disconnect permission and bits 2 to 0 the unit number.
// - bus device reset cancels everything for every initiator and goes to bus free.
`default_nettype none
`include "stmh_defines.vh"

module stmh_target #(
	parameter [2:0] TARGET_ID = 3'h7,
	parameter DIFF_VARIANT = 1'b1,
	parameter [3:0] SETUP_CYC = `STMH_SETUP_CYC
) (
	input wire clk,
	input wire reset_n,
	input wire bsy_in,
	input wire sel_in,
	input wire atn_in,
	input wire ack_in,
	input wire rst_in,
	input wire [7:0] db_in,
	input wire db_par_in,
	input wire diffsens,
	input wire parity_switch,
	input wire mode_parity_wr,
	input wire mode_parity_val,
	input wire op_valid,
	input wire [2:0] op_code,
	input wire [7:0] op_status,
	input wire [2:0] op_init_id,
	output reg bsy_oe,
	output reg sel_oe,
	output reg msg_oe,
	output reg cd_oe,
	output reg io_oe,
	output reg req_oe,
	output reg [7:0] db_out,
	output reg db_par_out,
	output reg db_oe,
	output reg diff_drv_en,
	output reg parity_en,
	output reg op_ready,
	output reg [2:0] init_id,
	output reg disc_perm,
	output reg ev_select,
	output reg ev_abort,
	output reg ev_bus_reset,
	output reg ev_init_err,
	output reg ev_rejected,
	output reg ev_parity,
	output reg ev_done
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SELW = 3'h1;
	localparam [2:0] ST_CONN = 3'h2;
	localparam [2:0] ST_XFER = 3'h3;
	localparam [2:0] ST_EVAL = 3'h4;
	localparam [2:0] ST_FREE = 3'h5;
	localparam [2:0] ST_RESEL = 3'h6;
	localparam [1:0] HS_SETUP = 2'h0;
	localparam [1:0] HS_REQ = 2'h1;
	localparam [1:0] HS_REL = 2'h2;

	reg [2:0] st_q;
	reg [1:0] hs_q;
	reg [3:0] cnt_q;
	reg [2:0] ctx_q;
	reg [7:0] rx_q;
	reg rx_par_q;
	reg [7:0] last_q;
	reg [2:0] last_ctx_q;
	reg [2:0] owner_q;
	reg owner_valid_q;
	reg strap_done_q;
	reg [2:0] sel_id;
	reg sel_hit;
	integer i;
	wire [3:0] cls;
	wire lun_zero;
	wire dp_bit;
	wire par_ok;

	stmh_msg_decode u_dec (
		.byte_in(rx_q),
		.par_in(rx_par_q),
		.check_en(parity_en),
		.cls(cls),
		.lun_zero(lun_zero),
		.disc_perm(dp_bit),
		.par_ok(par_ok)
	);

	// lowest id on the bus other than ours picks the selecting initiator
	always @* begin
		sel_id = 3'h0;
		sel_hit = 1'b0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (db_in[i] && (i[2:0] != TARGET_ID)) begin
				sel_id = i[2:0];
				sel_hit = 1'b1;
			end
		end
	end

	// start one byte over req/ack, outgoing when dir_in is set
	task start_xfer;
		input [7:0] b;
		input [2:0] ctx;
		input dir_in;
		input m;
		input c;
		begin
			st_q <= ST_XFER;
			hs_q <= HS_SETUP;
			cnt_q <= SETUP_CYC;
			ctx_q <= ctx;
			msg_oe <= m;
			cd_oe <= c;
			io_oe <= dir_in;
			db_oe <= dir_in;
			db_out <= b;
			db_par_out <= ~^b;
			if (dir_in && m) begin
				last_q <= b;
				last_ctx_q <= ctx;
			end
		end
	endtask

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_IDLE;
			hs_q <= HS_SETUP;
			cnt_q <= 4'h0;
			ctx_q <= `STMH_CTX_RX;
			rx_q <= 8'h00;
			rx_par_q <= 1'b0;
			last_q <= `STMH_MSG_REJECT;
			last_ctx_q <= `STMH_CTX_MSG;
			owner_q <= 3'h0;
			owner_valid_q <= 1'b0;
			strap_done_q <= 1'b0;
			bsy_oe <= 1'b0;
			sel_oe <= 1'b0;
			msg_oe <= 1'b0;
			cd_oe <= 1'b0;
			io_oe <= 1'b0;
			req_oe <= 1'b0;
			db_out <= 8'h00;
			db_par_out <= 1'b0;
			db_oe <= 1'b0;
			diff_drv_en <= 1'b0;
			parity_en <= 1'b0;
			op_ready <= 1'b0;
			init_id <= 3'h0;
			disc_perm <= 1'b0;
			ev_select <= 1'b0;
			ev_abort <= 1'b0;
			ev_bus_reset <= 1'b0;
			ev_init_err <= 1'b0;
			ev_rejected <= 1'b0;
			ev_parity <= 1'b0;
			ev_done <= 1'b0;
		end else begin
			ev_select <= 1'b0;
			ev_abort <= 1'b0;
			ev_bus_reset <= 1'b0;
			ev_init_err <= 1'b0;
			ev_rejected <= 1'b0;
			ev_parity <= 1'b0;
			ev_done <= 1'b0;
			op_ready <= 1'b0;
			diff_drv_en <= DIFF_VARIANT & diffsens;
			// switch caught once after reset, mode select overrides later
			strap_done_q <= 1'b1;
			if (!strap_done_q) begin
				parity_en <= parity_switch;
			end else if (mode_parity_wr) begin
				parity_en <= mode_parity_val;
			end
			if (rst_in) begin
				owner_valid_q <= 1'b0;
				ev_bus_reset <= 1'b1;
				st_q <= ST_FREE;
				req_oe <= 1'b0;
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (op_ready && op_valid && op_code == `STMH_OP_RESELECT) begin
							// drive both ids with sel and i/o, wait for initiator bsy
							st_q <= ST_RESEL;
							sel_oe <= 1'b1;
							io_oe <= 1'b1;
							db_oe <= 1'b1;
							db_out <= (8'h01 << TARGET_ID) | (8'h01 << owner_q);
							db_par_out <= ~^((8'h01 << TARGET_ID) | (8'h01 << owner_q));
							init_id <= owner_q;
						end else if (sel_in && !bsy_in && db_in[TARGET_ID] && sel_hit) begin
							bsy_oe <= 1'b1;
							init_id <= sel_id;
							disc_perm <= 1'b0;
							// nothing sent yet here, a parity retry answers with reject
							last_q <= `STMH_MSG_REJECT;
							last_ctx_q <= `STMH_CTX_MSG;
							st_q <= ST_SELW;
							// the command belongs to the initiator that starts it
							if (!owner_valid_q) begin
								owner_q <= sel_id;
								owner_valid_q <= 1'b1;
							end
						end else begin
							op_ready <= owner_valid_q;
						end
					end
					ST_SELW: begin
						if (!sel_in) begin
							ev_select <= 1'b1;
							if (atn_in) begin
								start_xfer(8'h00, `STMH_CTX_RX, 1'b0, 1'b1, 1'b1);
							end else begin
								st_q <= ST_CONN;
							end
						end
					end
					ST_RESEL: begin
						if (bsy_in) begin
							bsy_oe <= 1'b1;
							sel_oe <= 1'b0;
							// reselection identify reports unit zero only
							start_xfer(`STMH_MSG_IDENTIFY, `STMH_CTX_MSG, 1'b1, 1'b1, 1'b1);
						end
					end
					ST_CONN: begin
						if (op_ready && op_valid) begin
							case (op_code)
								// status byte first, command complete chained after it
								`STMH_OP_COMPLETE:
									start_xfer(op_status, `STMH_CTX_STATUS, 1'b1, 1'b0, 1'b1);
								`STMH_OP_SAVE_PTR:
									start_xfer(`STMH_MSG_SAVE_PTR, `STMH_CTX_MSG, 1'b1, 1'b1, 1'b1);
								`STMH_OP_RESTORE_PTR:
									start_xfer(`STMH_MSG_RESTORE_PTR, `STMH_CTX_MSG, 1'b1, 1'b1,
										1'b1);
								`STMH_OP_DISCONNECT:
									start_xfer(`STMH_MSG_DISCONNECT, `STMH_CTX_DISC, 1'b1, 1'b1,
										1'b1);
								default: st_q <= ST_CONN;
							endcase
						end else if (atn_in) begin
							start_xfer(8'h00, `STMH_CTX_RX, 1'b0, 1'b1, 1'b1);
						end else begin
							op_ready <= 1'b1;
						end
					end
					ST_XFER: begin
						// asynchronous req/ack only, no offset counting
						case (hs_q)
							HS_SETUP: begin
								if (cnt_q == 4'h0) begin
									req_oe <= 1'b1;
									hs_q <= HS_REQ;
								end else begin
									cnt_q <= cnt_q - 4'h1;
								end
							end
							HS_REQ: begin
								if (ack_in) begin
									if (!io_oe) begin
										rx_q <= db_in;
										rx_par_q <= db_par_in;
									end
									req_oe <= 1'b0;
									hs_q <= HS_REL;
								end
							end
							HS_REL: begin
								if (!ack_in) begin
									db_oe <= 1'b0;
									case (ctx_q)
										`STMH_CTX_RX: st_q <= ST_EVAL;
										`STMH_CTX_STATUS:
											start_xfer(`STMH_MSG_CMD_COMPLETE, `STMH_CTX_CC, 1'b1,
												1'b1, 1'b1);
										`STMH_CTX_CC: begin
											owner_valid_q <= 1'b0;
											ev_done <= 1'b1;
											st_q <= ST_FREE;
										end
										`STMH_CTX_DISC: st_q <= ST_FREE;
										default: st_q <= ST_CONN;
									endcase
								end
							end
							default: hs_q <= HS_SETUP;
						endcase
					end
					ST_EVAL: begin
						if (!par_ok) begin
							// drop the byte and ask for it again
							ev_parity <= 1'b1;
							start_xfer(8'h00, `STMH_CTX_RX, 1'b0, 1'b1, 1'b1);
						end else begin
							case (cls)
								`STMH_CLS_IDENTIFY: begin
									disc_perm <= dp_bit;
									if (lun_zero) begin
										st_q <= ST_CONN;
									end else begin
										start_xfer(`STMH_MSG_REJECT, `STMH_CTX_MSG, 1'b1, 1'b1,
											1'b1);
									end
								end
								`STMH_CLS_ABORT: begin
									// abort only counts from the owning initiator
									if (owner_valid_q && owner_q == init_id) begin
										owner_valid_q <= 1'b0;
										ev_abort <= 1'b1;
										st_q <= ST_FREE;
									end else begin
										st_q <= ST_CONN;
									end
								end
								`STMH_CLS_BUS_RESET: begin
									owner_valid_q <= 1'b0;
									ev_bus_reset <= 1'b1;
									st_q <= ST_FREE;
								end
								`STMH_CLS_REJECT: begin
									ev_rejected <= 1'b1;
									st_q <= ST_CONN;
								end
								`STMH_CLS_INIT_ERR: begin
									ev_init_err <= 1'b1;
									st_q <= ST_CONN;
								end
								`STMH_CLS_PAR_ERR:
									start_xfer(last_q, last_ctx_q, 1'b1, 1'b1, 1'b1);
								`STMH_CLS_NOP: st_q <= ST_CONN;
								default:
									start_xfer(`STMH_MSG_REJECT, `STMH_CTX_MSG, 1'b1, 1'b1, 1'b1);
							endcase
						end
					end
					ST_FREE: begin
						bsy_oe <= 1'b0;
						sel_oe <= 1'b0;
						msg_oe <= 1'b0;
						cd_oe <= 1'b0;
						io_oe <= 1'b0;
						req_oe <= 1'b0;
						db_oe <= 1'b0;
						st_q <= ST_IDLE;
					end
					default: st_q <= ST_FREE;
				endcase
			end
		end
	end
endmodule // stmh_target

`default_nettype wire

// *** test/stmh_target_checker.sv ***
/*
 concurrent checks on the ports of stmh_target.
 assumes one clock domain and the default handshake timing.
*/
`default_nettype none
module stmh_target_checker #(
	parameter DIFF_VARIANT = 1'b1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ack_in,
	input wire logic diffsens,
	input wire logic mode_parity_wr,
	input wire logic mode_parity_val,
	input wire logic bsy_oe,
	input wire logic sel_oe,
	input wire logic msg_oe,
	input wire logic cd_oe,
	input wire logic io_oe,
	input wire logic req_oe,
	input wire logic [7:0] db_out,
	input wire logic db_par_out,
	input wire logic db_oe,
	input wire logic diff_drv_en,
	input wire logic parity_en,
	input wire logic ev_bus_reset,
	input wire logic ev_abort,
	input wire logic ev_rejected,
	input wire logic ev_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic msg_in = req_oe && msg_oe && cd_oe && io_oe;
	logic status_q;
	// remembers a status byte taken during this connection
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n) status_q <= 1'b0;
		else if (!bsy_oe) status_q <= 1'b0;
		else if (req_oe && ack_in && !msg_oe && cd_oe && io_oe) status_q <= 1'b1;
	diff_follow_a: assert property (
		reset_n |=> diff_drv_en == ($past(diffsens) && DIFF_VARIANT))
		else $error("driver enable does not follow diffsens");
	req_drop_a: assert property (req_oe && ack_in |=> !req_oe)
		else $error("req held after ack");
	req_setup_a: assert property (
		$rose(req_oe) |-> $stable(db_out) && $stable({msg_oe, cd_oe, io_oe}) && db_oe == io_oe)
		else $error("phase or data moved at req");
	msg_set_a: assert property (
		msg_in |-> db_out inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h07, 8'h80, 8'hc0})
		else $error("unsupported message sent");
	ident_lun_a: assert property (msg_in && db_out[7] |-> db_out[5:0] == 6'h00)
		else $error("identify carries nonzero unit");
	cc_status_a: assert property (msg_in && db_out == 8'h00 |-> status_q)
		else $error("command complete before status");
	cc_free_a: assert property (ev_done |-> ##[0:3] !(bsy_oe || req_oe || db_oe))
		else $error("bus not freed after command complete");
	disc_free_a: assert property (msg_in && ack_in && db_out == 8'h04 |-> ##[1:12] !bsy_oe)
		else $error("bsy kept after disconnect");
	reset_free_a: assert property (ev_bus_reset |-> ##[0:3] !(bsy_oe || sel_oe || req_oe))
		else $error("bus not freed after device reset");
	parity_set_a: assert property (mode_parity_wr |=> parity_en == $past(mode_parity_val))
		else $error("parity enable not written");
	par_out_a: assert property (db_oe |-> ^{db_out, db_par_out})
		else $error("driven data without odd parity");
	cover property (ev_done);
	cover property (ev_abort);
	cover property (ev_rejected);
endmodule // stmh_target_checker
bind stmh_target stmh_target_checker #(.DIFF_VARIANT(DIFF_VARIANT)) i_stmh_target_checker (.*);
`default_nettype wire

// *** test/stmh_initiator_model.sv ***
/*
 behavioural initiator: acks target bytes and keeps data pointers.
 assumes the bench supplies the outgoing byte and the ack delay.
*/
`default_nettype none
module stmh_initiator_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req_oe,
	input wire logic io_oe,
	input wire logic msg_oe,
	input wire logic [7:0] db_out,
	input wire logic [7:0] tx_byte,
	input wire logic bad_par,
	input wire logic [3:0] ack_dly,
	output logic ack,
	output logic [7:0] db,
	output logic par,
	output logic [7:0] n_in,
	output logic [7:0] last_in,
	output logic [7:0] prev_in,
	output logic [7:0] act_ptr,
	output logic [7:0] sav_ptr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	wire logic drv = req_oe && !io_oe;
	// outside a request the lines show the inverse value
	assign db = drv ? tx_byte : ~tx_byte;
	assign par = drv ? (~^tx_byte) ^ bad_par : ^tx_byte;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{ack, cnt, n_in, last_in, prev_in, act_ptr, sav_ptr} <= '0;
		end else if (!req_oe) begin
			ack <= 1'b0;
			cnt <= 4'h0;
		end else if (!ack && cnt < ack_dly) begin
			cnt <= cnt + 4'h1;
		end else if (!ack) begin
			ack <= 1'b1;
			act_ptr <= act_ptr + 8'h01;
			if (io_oe) begin
				n_in <= n_in + 8'h01;
				{prev_in, last_in} <= {last_in, db_out};
			end
			if (io_oe && msg_oe && db_out == 8'h02) sav_ptr <= act_ptr;
			if (io_oe && msg_oe && (db_out == 8'h03 || db_out[7])) act_ptr <= sav_ptr;
		end
	end
endmodule // stmh_initiator_model
`default_nettype wire

// *** test/stmh_target_test.sv ***
/*
 self-checking bench for stmh_target with a behavioural initiator.
 assumes target id 7 and a 250 MHz clock.
*/
`default_nettype none
`include "stmh_defines.vh"
module stmh_target_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, b_bsy, b_sel, atn_in, rst_in, diffsens, parity_switch, clr;
	logic mode_parity_wr, mode_parity_val, op_valid, bad_par;
	logic [2:0] op_code;
	logic [3:0] dly;
	logic [6:0] ev_q;
	logic [7:0] op_status, sel_db, tx_byte, nb;
	int errors, n_checks, n, i;
	wire logic bsy_in, sel_in, ack_in, db_par_in, m_par, bsy_oe, sel_oe, msg_oe, cd_oe, io_oe;
	wire logic req_oe, db_oe, diff_drv_en, parity_en, op_ready, disc_perm, ev_select, ev_abort;
	wire logic ev_bus_reset, ev_init_err, ev_rejected, ev_parity, ev_done;
	wire logic [2:0] init_id;
	wire logic [7:0] db_in, db_out, m_db, n_in, last_in, prev_in, act_ptr, sav_ptr;
	// row: message byte, expected event bits, reject expected
	logic [15:0] rows [9] = '{16'h0510, 16'h0708, 16'h0800, 16'h0101, 16'h0201, 16'h0a01,
		16'h8101, 16'hc000, 16'h0901};
	assign bsy_in = b_bsy | bsy_oe;
	assign sel_in = b_sel | sel_oe;
	assign db_in = b_sel ? sel_db : m_db;
	assign db_par_in = b_sel ? ~^sel_db : m_par;
	stmh_target i_stmh_target (.*, .op_init_id(3'h0), .db_par_out());
	stmh_initiator_model i_stmh_initiator_model (.*, .ack(ack_in), .db(m_db), .par(m_par),
		.ack_dly(dly));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) ev_q <= clr ? 7'h00 : ev_q | {ev_select, ev_abort, ev_bus_reset,
		ev_init_err, ev_rejected, ev_parity, ev_done};
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic step;
		@(posedge clk);
		n++;
		if (n > 400) begin
			errors++;
			complete_run;
		end
	endtask
	task automatic send(input logic [7:0] msg);
		tx_byte <= msg;
		atn_in <= 1'b1;
		clr <= 1'b1;
		n = 0;
		while (!(req_oe && !io_oe)) step;
		atn_in <= 1'b0;
		clr <= 1'b0;
		while (bsy_oe && !(op_ready && !req_oe)) begin
			step;
			if (ev_q[1]) bad_par <= 1'b0;
		end
	endtask
	task automatic select(input logic [7:0] ids, input logic [7:0] msg);
		sel_db <= ids;
		b_sel <= 1'b1;
		atn_in <= 1'b1;
		n = 0;
		while (!bsy_oe) step;
		b_sel <= 1'b0;
		step;
		step;
		chk(ev_select, 1'b1);
		send(msg);
	endtask
	task automatic op(input logic [2:0] code);
		op_code <= code;
		op_valid <= 1'b1;
		n = 0;
		do step; while (!op_ready);
		op_valid <= 1'b0;
		do step; while (bsy_oe && !(op_ready && !req_oe));
	endtask
	initial begin
		{reset_n, b_bsy, b_sel, atn_in, rst_in, mode_parity_wr, mode_parity_val, op_valid} = '0;
		{bad_par, clr, op_code, op_status, sel_db, tx_byte, dly} = '0;
		diffsens = 1'b1;
		parity_switch = 1'b1;
		errors = 0;
		n_checks = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(parity_en, 1'b1);
		select(8'h81, 8'h80);
		chk({init_id, disc_perm}, 4'h0);
		foreach (rows[k]) begin
			nb = n_in;
			send(rows[k][15:8]);
			chk({ev_q, n_in - nb}, {rows[k][7:1], 8'(rows[k][0])});
			if (rows[k][0]) chk(last_in, 8'h07);
		end
		chk(disc_perm, 1'b1);
		dly <= 4'h3;
		bad_par <= 1'b1;
		send(8'h08);
		chk({ev_q[1], bad_par}, 2'b10);
		mode_parity_wr <= 1'b1;
		@(posedge clk) mode_parity_wr <= 1'b0;
		bad_par <= 1'b1;
		send(8'h08);
		chk({ev_q[1], parity_en}, 2'b00);
		bad_par <= 1'b0;
		dly <= 4'h0;
		op(`STMH_OP_SAVE_PTR);
		chk({last_in, sav_ptr}, {8'h02, act_ptr - 8'h01});
		send(8'h08);
		op(`STMH_OP_RESTORE_PTR);
		chk({last_in, act_ptr}, {8'h03, sav_ptr});
		op(`STMH_OP_DISCONNECT);
		chk({last_in, bsy_oe}, {8'h04, 1'b0});
		op(`STMH_OP_RESELECT);
		n = 0;
		while (!sel_oe) step;
		chk({db_out, bsy_oe}, {8'h81, 1'b0});
		b_bsy <= 1'b1;
		while (sel_oe) step;
		b_bsy <= 1'b0;
		while (!(op_ready && !req_oe)) step;
		chk({last_in, bsy_oe}, {8'h80, 1'b1});
		op_status <= 8'h02;
		op(`STMH_OP_COMPLETE);
		chk({prev_in, last_in, bsy_oe, ev_q[0]}, {8'h02, 8'h00, 2'b01});
		select(8'h82, 8'h80);
		chk(init_id, 3'h1);
		send(8'h06);
		chk({ev_q[5], bsy_oe}, 2'b10);
		select(8'h84, 8'h0c);
		chk({ev_q[4], bsy_oe, op_ready}, 3'b100);
		for (i = 0; i < 2; i++) begin
			diffsens <= i[0];
			repeat (2) @(posedge clk);
			chk(diff_drv_en, i[0]);
		end
		// parity retry as first message of a new connection must not replay old bytes
		select(8'h88, 8'h09);
		chk({last_in, ev_q[0]}, {8'h07, 1'b0});
		rst_in <= 1'b1;
		step;
		rst_in <= 1'b0;
		while (bsy_oe) step;
		chk({ev_q[4], bsy_oe, init_id}, {2'b10, 3'h3});
		mode_parity_val <= 1'b1;
		mode_parity_wr <= 1'b1;
		@(posedge clk) mode_parity_wr <= 1'b0;
		@(posedge clk);
		chk(parity_en, 1'b1);
		// reset in mid-run, switch caught again after release
		reset_n <= 1'b0;
		@(posedge clk);
		chk({bsy_oe, parity_en, diff_drv_en, op_ready}, 4'h0);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk({parity_en, diff_drv_en, op_ready}, 3'b110);
		complete_run;
	end
endmodule // stmh_target_test
`default_nettype wire
